// *** logic/asram_defs.vh ***
// Constants for the asynchronous static memory host controller.
// Behaviour
// R01: A write happens only while select, strobe and a lane enable are all low.
// R02: Write data setup and hold are timed against the edge ending the write.
// R03: Write data is valid 6 ns before write end, held until that edge.
// R04: Address is stable at write start and valid 7 ns before write end.
// R05: Select, strobe and chosen lane enables stay low 7 ns before write end.
// R06: Device gives read data within 10 ns of the address settling.
// R07: Device holds previous data 3 ns after an address change.
// R08: Read data is valid within 5 ns of output or lane enable falling.
// R09: Read data is valid within 10 ns of select falling.
// R10: Device outputs float within 5 ns of disable events or strobe falling.
// R11: Device turn-off delay is always shorter than its turn-on delay.
// R12: Host waits at least 100 us after power is good before first access.
// R13: Device enters low power within 10 ns of select rising.
// R14: Host deasserts select before the supply drops to retention level.
// R15: Host waits one read-cycle time after leaving retention before accessing.
// R16: Host keeps the write strobe high during every read cycle.
// R17: Host makes the address valid no later than select falls in a read.
// R18: Device floats both lanes with output enable high or both lanes disabled.
// R19: Select and strobe rising together leave the device outputs floating.
// R20: Low lane enable gates bits 7..0, high lane enable bits 15..8.
`ifndef ASRAM_DEFS_VH
`define ASRAM_DEFS_VH
`define ASRAM_CLK_NS          25
`define ASRAM_POWERUP_WAIT_NS 100000
`define ASRAM_READ_CYCLE_NS   10
`define ASRAM_ADDR_ACCESS_NS  10
`define ASRAM_WR_WIDTH_NS     7
`define ASRAM_FLOAT_NS        5
`define ASRAM_CEIL_CYC(ns)    (((ns) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_ST_POWERUP      3'h0
`define ASRAM_ST_IDLE         3'h1
`define ASRAM_ST_RD           3'h2
`define ASRAM_ST_WR           3'h3
`define ASRAM_ST_WR_END       3'h4
`define ASRAM_ST_RECOVER      3'h5
`define ASRAM_ST_RETAIN       3'h6
`define ASRAM_ST_TURN         3'h7
`endif

// *** logic/asram_host.v ***
// Host controller driving an asynchronous 16-bit static memory through its pins.
`timescale 1ns/100ps
`include "asram_defs.vh"
module asram_host #(
	parameter AW              = 16,
	parameter DW              = 16,
	parameter POWERUP_WAIT_NS = `ASRAM_POWERUP_WAIT_NS
) (
	// Clock and reset.
	input  wire          sys_clk_i,
	input  wire          resetn_i,
	// User request port.
	input  wire          req_valid_i,
	input  wire          req_write_i,
	input  wire [AW-1:0] req_addr_i,
	input  wire [DW-1:0] req_wdata_i,
	input  wire [1:0]    req_lanes_i,
	output reg           req_ready_o,
	output reg           rsp_valid_o,
	output reg  [DW-1:0] rsp_rdata_o,
	// Power management.
	input  wire          retain_req_i,
	output reg           retain_ok_o,
	// Memory pins.
	output reg  [AW-1:0] mem_addr_o,
	output reg           mem_cs_n_o,
	output reg           mem_oe_n_o,
	output reg           mem_we_n_o,
	output reg           low_lane_enable_n_o,
	output reg           high_lane_enable_n_o,
	input  wire [DW-1:0] data_bus_i,
	output reg  [DW-1:0] data_bus_o,
	output reg           data_bus_oe_o
);
	localparam PWR_CYC = (POWERUP_WAIT_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS;
	localparam RD_CYC  = `ASRAM_CEIL_CYC(`ASRAM_ADDR_ACCESS_NS + `ASRAM_FLOAT_NS);
	localparam WR_CYC  = `ASRAM_CEIL_CYC(`ASRAM_WR_WIDTH_NS);
	localparam REC_CYC = `ASRAM_CEIL_CYC(`ASRAM_READ_CYCLE_NS);
	localparam TRN_CYC = `ASRAM_CEIL_CYC(`ASRAM_FLOAT_NS);
	localparam CW      = 13;

	reg [2:0]    state_r;
	reg [CW-1:0] cnt_r;
	reg          wr_r;

	always @(posedge sys_clk_i) begin
		rsp_valid_o <= 1'b0;
		if (!resetn_i) begin
			state_r              <= `ASRAM_ST_POWERUP;
			cnt_r                <= PWR_CYC[CW-1:0];
			wr_r                 <= 1'b0;
			req_ready_o          <= 1'b0;
			rsp_rdata_o          <= {DW{1'b0}};
			retain_ok_o          <= 1'b0;
			mem_addr_o           <= {AW{1'b0}};
			mem_cs_n_o           <= 1'b1;
			mem_oe_n_o           <= 1'b1;
			mem_we_n_o           <= 1'b1;
			low_lane_enable_n_o  <= 1'b1;
			high_lane_enable_n_o <= 1'b1;
			data_bus_o           <= {DW{1'b0}};
			data_bus_oe_o        <= 1'b0;
		end else begin
			case (state_r)
			`ASRAM_ST_POWERUP: begin
				// Hold off all accesses until the power-up wait has run out. [R12]
				if (cnt_r > 1) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					state_r     <= `ASRAM_ST_IDLE;
					req_ready_o <= 1'b1;
				end
			end
			`ASRAM_ST_IDLE: begin
				mem_cs_n_o           <= 1'b1;
				mem_oe_n_o           <= 1'b1;
				mem_we_n_o           <= 1'b1;
				low_lane_enable_n_o  <= 1'b1;
				high_lane_enable_n_o <= 1'b1;
				if (retain_req_i) begin
					// Select is already high before retention is granted. [R14]
					req_ready_o <= 1'b0;
					retain_ok_o <= 1'b1;
					state_r     <= `ASRAM_ST_RETAIN;
				end else if (req_valid_i && req_ready_o) begin
					req_ready_o <= 1'b0;
					wr_r        <= req_write_i;
					// Address is set with select in the same edge. [R04] [R17]
					mem_addr_o  <= req_addr_i;
					mem_cs_n_o  <= 1'b0;
					// Lane 0 is bits 7..0, lane 1 is bits 15..8. [R20]
					low_lane_enable_n_o  <= ~req_lanes_i[0];
					high_lane_enable_n_o <= ~req_lanes_i[1];
					if (req_write_i) begin
						// Data is driven in the same edge as the strobe and is held past the end. [R02] [R03]
						data_bus_o    <= req_wdata_i;
						data_bus_oe_o <= 1'b1;
						mem_we_n_o    <= 1'b0;
						cnt_r         <= WR_CYC[CW-1:0];
						state_r       <= `ASRAM_ST_WR;
					end else begin
						// Strobe stays high for the whole read. [R16]
						mem_oe_n_o <= 1'b0;
						cnt_r      <= RD_CYC[CW-1:0];
						state_r    <= `ASRAM_ST_RD;
					end
				end
			end
			`ASRAM_ST_RD: begin
				if (cnt_r > 1) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					rsp_rdata_o <= data_bus_i;
					rsp_valid_o <= 1'b1;
					mem_oe_n_o  <= 1'b1;
					mem_cs_n_o  <= 1'b1;
					cnt_r       <= TRN_CYC[CW-1:0];
					state_r     <= `ASRAM_ST_TURN;
				end
			end
			`ASRAM_ST_WR: begin
				// Select, strobe and chosen lanes stay low for the full width. [R01] [R05]
				if (cnt_r > 1) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					mem_we_n_o <= 1'b1;
					mem_cs_n_o <= 1'b1;
					state_r    <= `ASRAM_ST_WR_END;
				end
			end
			`ASRAM_ST_WR_END: begin
				// Data is released one cycle after the write-ending edge. [R03]
				data_bus_oe_o <= 1'b0;
				cnt_r         <= TRN_CYC[CW-1:0];
				state_r       <= `ASRAM_ST_TURN;
			end
			`ASRAM_ST_TURN: begin
				low_lane_enable_n_o  <= 1'b1;
				high_lane_enable_n_o <= 1'b1;
				if (cnt_r > 1) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					req_ready_o <= 1'b1;
					state_r     <= `ASRAM_ST_IDLE;
				end
			end
			`ASRAM_ST_RETAIN: begin
				if (!retain_req_i) begin
					retain_ok_o <= 1'b0;
					cnt_r       <= REC_CYC[CW-1:0];
					state_r     <= `ASRAM_ST_RECOVER;
				end
			end
			`ASRAM_ST_RECOVER: begin
				// One read-cycle time passes before access resumes. [R15]
				if (cnt_r > 1) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					req_ready_o <= 1'b1;
					state_r     <= `ASRAM_ST_IDLE;
				end
			end
			default: begin
				state_r <= `ASRAM_ST_IDLE;
			end
			endcase
		end
	end
endmodule // asram_host

// *** verif/asram_host_bench.sv ***
// Bench for the static memory host controller.
`timescale 1ns/100ps
module asram_host_bench;
	reg        clk = 0, rst_n = 0, vld = 0, wr = 0, ret = 0;
	reg [15:0] a = 0, d = 0, got;
	reg [1:0]  ln = 0;
	integer    num_errors = 0, samples_checked = 0, i;
	wire       rdy, rv, rok, cs_n, oe_n, we_n, lle_n, hle_n, doe;
	wire [15:0] rdat, ma, dq, mq;
	wire [15:0] bus = doe ? dq : mq;
	initial forever #12.5 clk = ~clk;
	asram_host #(.POWERUP_WAIT_NS(250)) dut (.sys_clk_i(clk), .resetn_i(rst_n), .req_valid_i(vld),
		.req_write_i(wr), .req_addr_i(a), .req_wdata_i(d), .req_lanes_i(ln), .req_ready_o(rdy),
		.rsp_valid_o(rv), .rsp_rdata_o(rdat), .retain_req_i(ret), .retain_ok_o(rok),
		.mem_addr_o(ma), .mem_cs_n_o(cs_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n),
		.low_lane_enable_n_o(lle_n), .high_lane_enable_n_o(hle_n), .data_bus_i(bus),
		.data_bus_o(dq), .data_bus_oe_o(doe));
	asram_mem_model mem (.addr_i(ma), .bus_i(bus), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.lle_n_i(lle_n), .hle_n_i(hle_n), .q_o(mq));
	task chk(input [8*6:1] n, input [15:0] s, e); begin
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0s exp %h got %h", n, e, s);
		end
	end endtask
	task wait_rdy; for (i = 0; i < 99 && rdy !== 1'b1; i++) @(negedge clk); endtask
	task op(input w, input [15:0] ad, dd, input [1:0] l); begin
		wait_rdy;
		{wr, a, d, ln, vld} = {w, ad, dd, l, 1'b1};
		@(negedge clk);
		vld = 0;
		for (i = 0; i < 9 && !w && rv !== 1'b1; i++) @(negedge clk);
		got = rdat;
	end endtask
	task t_power; begin
		for (i = 0; rdy !== 1'b1 && i < 99; i++) @(negedge clk);
		chk("pwrup", i >= 9, 1);
	end endtask
	task t_lanes; begin
		op(1, 5, 16'h1234, 3);
		op(0, 5, 0, 3);
		chk("rdall", got, 16'h1234);
		op(1, 5, 16'hABCD, 1);
		op(1, 5, 16'h5600, 2);
		op(1, 5, 16'hFFFF, 0);
		op(0, 5, 0, 3);
		chk("rdlane", got, 16'h56CD);
	end endtask
	task t_retain; begin
		wait_rdy;
		ret = 1;
		repeat (2) @(negedge clk);
		chk("retok", {rok, cs_n, rdy}, 3'b110);
		ret = 0;
		op(0, 5, 0, 3);
		chk("rdret", got, 16'h56CD);
	end endtask
	task test_done; begin
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	end endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		t_power;
		t_lanes;
		t_retain;
		test_done;
	end
	initial begin
		#20000;
		num_errors++;
		test_done;
	end
endmodule // asram_host_bench

// *** verif/asram_host_props.sv ***
// Checker for the static memory host controller pins.
`timescale 1ns/100ps
module asram_host_props #(parameter POWERUP_WAIT_NS = 250) (
	input wire        sys_clk_i, resetn_i, retain_ok_o, mem_cs_n_o, mem_oe_n_o, mem_we_n_o,
	input wire        data_bus_oe_o,
	input wire [15:0] mem_addr_o, data_bus_o
);
	localparam PWR = (POWERUP_WAIT_NS + 24) / 25;
	reg [15:0] up_r;
	always @(posedge sys_clk_i) up_r <= !resetn_i ? 16'h0000 : up_r + (up_r != 16'hffff);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wr_window_a: assert property (!mem_we_n_o |-> !mem_cs_n_o && data_bus_oe_o)
		else $error("write strobe low outside select");
	wr_data_a: assert property (!mem_we_n_o |=> $stable(data_bus_o) && data_bus_oe_o)
		else $error("write data not held to write end");
	addr_hold_a: assert property (!mem_cs_n_o |=> $stable(mem_addr_o))
		else $error("address moved while selected");
	wr_width_a: assert property ($fell(mem_we_n_o) |-> ##1 mem_we_n_o && mem_cs_n_o)
		else $error("write pulse width wrong");
	power_wait_a: assert property (!mem_cs_n_o |-> up_r >= PWR)
		else $error("access before power-up wait");
	retain_cs_a: assert property (retain_ok_o |-> mem_cs_n_o && mem_we_n_o)
		else $error("selected during retention");
	recover_a: assert property ($fell(retain_ok_o) |-> mem_cs_n_o ##1 mem_cs_n_o)
		else $error("access too soon after retention");
	rd_we_high_a: assert property (!mem_oe_n_o |-> mem_we_n_o)
		else $error("write strobe low in read");
	rd_c: cover property (!mem_oe_n_o && !mem_cs_n_o);
	wr_c: cover property (!mem_we_n_o);
	ret_c: cover property (retain_ok_o);
endmodule // asram_host_props
bind asram_host asram_host_props #(.POWERUP_WAIT_NS(POWERUP_WAIT_NS)) u_props (.*);

// *** verif/asram_mem_model.sv ***
// Behavioural 64K x 16 static memory facing the host controller.
`timescale 1ns/100ps
module asram_mem_model (
	input  wire [15:0] addr_i, bus_i,
	input  wire        cs_n_i, oe_n_i, we_n_i, lle_n_i, hle_n_i,
	output wire [15:0] q_o
);
	reg [15:0] mem [0:65535];
	reg [15:0] last_r = 16'h0000;
	wire       rd = !cs_n_i && !oe_n_i && we_n_i;
	always @* if (!cs_n_i && !we_n_i) begin
		if (!lle_n_i) mem[addr_i][7:0] = bus_i[7:0];
		if (!hle_n_i) mem[addr_i][15:8] = bus_i[15:8];
	end
	always @* if (rd) last_r = mem[addr_i];
	// Floating lanes show the inverse of the last value.
	assign #5 q_o = {rd && !hle_n_i ? mem[addr_i][15:8] : ~last_r[15:8],
		rd && !lle_n_i ? mem[addr_i][7:0] : ~last_r[7:0]};
endmodule // asram_mem_model
